// ===== rtl/mcu_watchdog_idle_control.sv
// Contract
// - Watchdog ticks on a one millisecond timebase
// - No counting before a start-of-frame seen
// - Unserviced enabled watchdog resets MCU after 32 ms
// - Five-bit counter; expiry produces device reset
// - Writing one to service bit restarts count
// - Service bit always reads as zero
// - Writing one to enable bit starts watchdog
// - Enable cleared only by power-up or USB reset
// - Reset cause set on timeout, cleared by resets
// - Reset cause cleared by writing one, not by writing zero
// - Idle suspends watchdog counting and timeout
// - Wake interrupt clears idle, watchdog resumes
// - Idle set by firmware, cleared only by interrupt
// - Interrupt must stay asserted 400 us to wake
// - Idle stops MCU, RAM, oscillator and PLL
// - Two general flags, read-write, reset zero
// - Read-write baud doubling bit, reset zero
`timescale 1ns/1ps
module mcu_watchdog_idle_control
    import watchdog_idle_pkg::*;
#(
    parameter int TICK_COUNT = TICK_CYCLES,
    parameter int WAKE_COUNT = WAKE_HOLD_CYCLES
)
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_write,
    input  wire logic        sfr_read,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [15:0] xdata_addr,
    input  wire logic        xdata_write,
    input  wire logic        xdata_read,
    input  wire logic [7:0]  xdata_wdata,
    output logic      [7:0]  xdata_rdata,
    input  wire logic        sof_detected,
    input  wire logic        usb_reset,
    input  wire logic        usb_reset_enable,
    input  wire logic        external_interrupt_one_n,
    output logic             mcu_reset,
    output logic             wake_interrupt,
    output logic             mcu_idle,
    output logic             ram_low_power,
    output logic             osc_pll_stop,
    output logic             baud_double
);

    localparam int TICK_W = $clog2(TICK_COUNT + 1);
    localparam int WAKE_W = $clog2(WAKE_COUNT + 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_COUNT - 1);
    localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_COUNT - 1);
    localparam logic [WATCHDOG_WIDTH-1:0] WD_LAST = '1;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [TICK_W-1:0]         tick_count;
    logic                      tick;
    logic [WATCHDOG_WIDTH-1:0] wd_count;
    logic                      sof_seen;
    logic                      watchdog_enable_bit;
    logic                      reset_cause_flag;
    logic                      idle_bit;
    logic                      general_flag_high;
    logic                      general_flag_low;
    logic                      baud_double_bit;
    logic [WAKE_W-1:0]         wake_count;

    logic [TICK_W-1:0]         next_tick_count;
    logic                      next_tick;
    logic [WATCHDOG_WIDTH-1:0] next_wd_count;
    logic                      next_sof_seen;
    logic                      next_watchdog_enable_bit;
    logic                      next_reset_cause_flag;
    logic                      next_idle_bit;
    logic                      next_general_flag_high;
    logic                      next_general_flag_low;
    logic                      next_baud_double_bit;
    logic [WAKE_W-1:0]         next_wake_count;
    logic                      next_mcu_reset;
    logic                      next_wake_interrupt;
    logic [7:0]                next_sfr_rdata;
    logic [7:0]                next_xdata_rdata;

    logic power_control_wr;
    logic watchdog_control_status_wr;
    logic counting;
    logic expire;
    logic wake_done;
    logic usb_clear;

    function automatic logic [7:0] watchdog_control_status_image(input logic en, input logic cause);
        logic [7:0] v;
        v = REG_RESET_VALUE;
        v[WATCHDOG_ENABLE_POS] = en;
        v[RESET_CAUSE_POS]     = cause;
        return v;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        power_control_wr   = sfr_write && (sfr_addr == POWER_CONTROL_ADDR);
        watchdog_control_status_wr  = xdata_write && (xdata_addr == WATCHDOG_CONTROL_STATUS_ADDR);
        usb_clear = usb_reset && usb_reset_enable;

        // Free-running millisecond timebase
        next_tick       = (tick_count == TICK_LAST);
        next_tick_count = next_tick ? '0 : tick_count + 1'b1;

        next_sof_seen = sof_seen || sof_detected;
        if (usb_clear)
        begin
            next_sof_seen = 1'b0;
        end

        // Idle freezes the count in place rather than clearing it
        counting = watchdog_enable_bit && sof_seen && !idle_bit;
        expire   = counting && tick && (wd_count == WD_LAST);

        next_wd_count = wd_count;
        if (counting && tick)
        begin
            next_wd_count = wd_count + 1'b1;
        end
        if (watchdog_control_status_wr && xdata_wdata[SERVICE_BIT_POS])
        begin
            next_wd_count = '0;
        end
        if (expire || usb_clear)
        begin
            next_wd_count = '0;
        end
        next_mcu_reset = expire;

        next_watchdog_enable_bit = watchdog_enable_bit;
        if (watchdog_control_status_wr && xdata_wdata[WATCHDOG_ENABLE_POS])
        begin
            next_watchdog_enable_bit = 1'b1;
        end
        if (usb_clear)
        begin
            next_watchdog_enable_bit = 1'b0;
        end

        // Timeout wins over a same-cycle write-one clear; a same-cycle USB reset still clears the cause
        next_reset_cause_flag = reset_cause_flag;
        if (watchdog_control_status_wr && xdata_wdata[RESET_CAUSE_POS])
        begin
            next_reset_cause_flag = 1'b0;
        end
        if (expire)
        begin
            next_reset_cause_flag = 1'b1;
        end
        if (usb_clear)
        begin
            next_reset_cause_flag = 1'b0;
        end

        // Wake needs an unbroken low on the interrupt pin
        next_wake_count = '0;
        if (idle_bit && !external_interrupt_one_n && wake_count != WAKE_LAST)
        begin
            next_wake_count = wake_count + 1'b1;
        end
        wake_done = idle_bit && !external_interrupt_one_n
                    && (wake_count == WAKE_LAST);
        next_wake_interrupt = wake_done;

        next_idle_bit = idle_bit;
        if (wake_done)
        begin
            next_idle_bit = 1'b0;
        end
        if (power_control_wr && sfr_wdata[IDLE_BIT_POS])
        begin
            next_idle_bit = 1'b1;
        end

        next_general_flag_high = general_flag_high;
        next_general_flag_low  = general_flag_low;
        next_baud_double_bit   = baud_double_bit;
        if (power_control_wr)
        begin
            next_general_flag_high = sfr_wdata[GENERAL_HIGH_POS];
            next_general_flag_low  = sfr_wdata[GENERAL_LOW_POS];
            next_baud_double_bit   = sfr_wdata[BAUD_DOUBLE_POS];
        end

        // Read data registered; unmapped addresses and reserved bits give zero
        next_sfr_rdata = REG_RESET_VALUE;
        if (sfr_read && sfr_addr == POWER_CONTROL_ADDR)
        begin
            next_sfr_rdata[IDLE_BIT_POS]     = idle_bit;
            next_sfr_rdata[GENERAL_LOW_POS]  = general_flag_low;
            next_sfr_rdata[GENERAL_HIGH_POS] = general_flag_high;
            next_sfr_rdata[BAUD_DOUBLE_POS]  = baud_double_bit;
        end
        next_xdata_rdata = REG_RESET_VALUE;
        if (xdata_read && xdata_addr == WATCHDOG_CONTROL_STATUS_ADDR)
        begin
            next_xdata_rdata = watchdog_control_status_image(watchdog_enable_bit,
                                           reset_cause_flag);
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_count          <= '0;
            tick                <= 1'b0;
            wd_count            <= '0;
            sof_seen            <= 1'b0;
            watchdog_enable_bit <= 1'b0;
            reset_cause_flag    <= 1'b0;
            idle_bit            <= 1'b0;
            general_flag_high   <= 1'b0;
            general_flag_low    <= 1'b0;
            baud_double_bit     <= 1'b0;
            wake_count          <= '0;
            mcu_reset           <= 1'b0;
            wake_interrupt      <= 1'b0;
            mcu_idle            <= 1'b0;
            ram_low_power       <= 1'b0;
            osc_pll_stop        <= 1'b0;
            baud_double         <= 1'b0;
            sfr_rdata           <= REG_RESET_VALUE;
            xdata_rdata         <= REG_RESET_VALUE;
        end
        else
        begin
            tick                <= next_tick;
            tick_count          <= next_tick_count;
            wd_count            <= next_wd_count;
            sof_seen            <= next_sof_seen;
            watchdog_enable_bit <= next_watchdog_enable_bit;
            reset_cause_flag    <= next_reset_cause_flag;
            idle_bit            <= next_idle_bit;
            general_flag_high   <= next_general_flag_high;
            general_flag_low    <= next_general_flag_low;
            baud_double_bit     <= next_baud_double_bit;
            wake_count          <= next_wake_count;
            mcu_reset           <= next_mcu_reset;
            wake_interrupt      <= next_wake_interrupt;
            mcu_idle            <= next_idle_bit;
            ram_low_power       <= next_idle_bit;
            osc_pll_stop        <= next_idle_bit;
            baud_double         <= next_baud_double_bit;
            sfr_rdata           <= next_sfr_rdata;
            xdata_rdata         <= next_xdata_rdata;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    AST_TICK_SPACING: assert property (tick |=> !tick)
        else $error("timebase tick lasted more than one cycle");

    AST_NO_SOF_HOLD: assert property (!sof_seen && !usb_clear && !watchdog_control_status_wr
        |=> wd_count == $past(wd_count))
        else $error("watchdog counted before start-of-frame");

    AST_EXPIRY_RESET: assert property (watchdog_enable_bit && sof_seen && !idle_bit
        && tick && wd_count == WD_LAST |=> mcu_reset && wd_count == '0)
        else $error("watchdog expiry did not reset the MCU");

    AST_RESET_PULSE: assert property (mcu_reset |=> !mcu_reset)
        else $error("MCU reset pulse lasted more than one cycle");

    AST_STEP: assert property (counting && tick && wd_count != WD_LAST && !watchdog_control_status_wr
        && !usb_clear |=> wd_count == $past(wd_count) + 1'b1)
        else $error("watchdog count did not advance on tick");

    AST_SERVICE_RESTART: assert property (watchdog_control_status_wr && xdata_wdata[SERVICE_BIT_POS]
        |=> wd_count == '0)
        else $error("service write did not restart count");

    AST_SERVICE_READS_ZERO: assert property (xdata_read
        |=> xdata_rdata[RESET_CAUSE_POS-1:SERVICE_BIT_POS] == '0)
        else $error("service or reserved bit read nonzero");

    AST_ENABLE_SET: assert property (watchdog_control_status_wr && xdata_wdata[WATCHDOG_ENABLE_POS]
        && !usb_clear |=> watchdog_enable_bit)
        else $error("enable write did not start the watchdog");

    AST_ENABLE_STICKY: assert property (watchdog_enable_bit && !usb_clear
        |=> watchdog_enable_bit)
        else $error("enable cleared without USB reset");

    // A USB reset in the expiry cycle legally clears enable and cause
    AST_ENABLE_SURVIVES: assert property (expire && !usb_clear
        |=> mcu_reset && watchdog_enable_bit && reset_cause_flag)
        else $error("timeout reset lost enable or cause");

    AST_USB_CLEARS: assert property (usb_clear
        |=> !watchdog_enable_bit && !reset_cause_flag && !sof_seen && wd_count == '0)
        else $error("USB reset did not clear the watchdog");

    AST_CAUSE_ZERO_WRITE: assert property (reset_cause_flag && watchdog_control_status_wr
        && !xdata_wdata[RESET_CAUSE_POS] && !usb_clear |=> reset_cause_flag)
        else $error("writing zero changed reset cause");

    AST_IDLE_FREEZE: assert property (idle_bit && !usb_clear && !watchdog_control_status_wr
        |=> wd_count == $past(wd_count) && !mcu_reset)
        else $error("watchdog moved while idle");

    AST_IDLE_STICKY: assert property (idle_bit && !wake_done |=> idle_bit)
        else $error("idle cleared without wake interrupt");

    AST_WAKE_CLEARS: assert property (wake_done && !power_control_wr
        |=> !idle_bit && wake_interrupt && !mcu_idle)
        else $error("wake did not clear idle");

    AST_NO_WAKE_AWAKE: assert property (!idle_bit |=> !wake_interrupt)
        else $error("wake pin acted while not idle");

    AST_WAKE_RESTART: assert property (idle_bit && external_interrupt_one_n
        |=> wake_count == '0)
        else $error("high pin sample did not restart the hold count");

    AST_IDLE_OUTPUTS: assert property (mcu_idle == idle_bit
        && ram_low_power == idle_bit && osc_pll_stop == idle_bit)
        else $error("idle outputs disagree with idle bit");

    AST_FLAGS_WRITE: assert property (power_control_wr
        |=> general_flag_low == $past(sfr_wdata[GENERAL_LOW_POS])
        && general_flag_high == $past(sfr_wdata[GENERAL_HIGH_POS])
        && baud_double == $past(sfr_wdata[BAUD_DOUBLE_POS]))
        else $error("power control write not stored");

    COV_EXPIRE: cover property (mcu_reset);
    COV_WAKE:   cover property (wake_interrupt);
    COV_SERVICE: cover property (counting ##1 watchdog_control_status_wr && xdata_wdata[SERVICE_BIT_POS]);
    COV_CAUSE_CLEAR: cover property (reset_cause_flag ##1 !reset_cause_flag);

endmodule

// ===== rtl/watchdog_idle_pkg.sv
package watchdog_idle_pkg;

    // ------------------------------------------------------------
    // Register locations
    // ------------------------------------------------------------
    localparam logic [7:0]  POWER_CONTROL_ADDR           = 8'h87;
    localparam logic [15:0] WATCHDOG_CONTROL_STATUS_ADDR = 16'hFF93;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SERVICE_BIT_POS     = 0;
    localparam int RESET_CAUSE_POS     = 6;
    localparam int WATCHDOG_ENABLE_POS = 7;
    localparam int IDLE_BIT_POS        = 0;
    localparam int GENERAL_LOW_POS     = 2;
    localparam int GENERAL_HIGH_POS    = 3;
    localparam int BAUD_DOUBLE_POS     = 7;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] REG_RESET_VALUE = 8'h00;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS    = 10;
    localparam int TICK_PERIOD_US     = 1000;
    localparam int WAKE_HOLD_US       = 400;
    localparam int TICK_CYCLES        = TICK_PERIOD_US * 1000 / CLOCK_PERIOD_NS;
    localparam int WAKE_HOLD_CYCLES   =
        (WAKE_HOLD_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int WATCHDOG_WIDTH     = 5;

endpackage

// ===== verif/wake_pin_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// Wake pin driver, standing in for the outside party
// ------------------------------------------------------------
module wake_pin_model (
    input  wire logic        clock,
    input  wire logic        start,
    input  wire logic [15:0] hold,
    output logic             pin_n
);
    logic [15:0] left;

    initial left = 16'h0000;

    // Pin rests high between pulses, as through its pull-up
    assign pin_n = (left == 16'h0000);

    // Low for exactly hold cycles; a short hold is the only misbehaviour
    always @(negedge clock)
    begin
        if (start && left == 16'h0000)
            left <= hold;
        else if (left != 16'h0000)
            left <= left - 16'h0001;
    end
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import watchdog_idle_pkg::*;
    localparam int          TK    = 8;
    localparam int          WK    = 4;
    localparam int          LIMIT = 10000;
    localparam logic [15:0] WDA   = WATCHDOG_CONTROL_STATUS_ADDR;
    localparam logic [15:0] PCA   = {8'h00, POWER_CONTROL_ADDR};
    logic        clock, rst_n, sfr_write, sfr_read, xdata_write, xdata_read;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xdata_wdata, xdata_rdata;
    logic [15:0] xdata_addr, pin_hold;
    logic        sof_detected, usb_reset, usb_reset_enable, pin_n, pin_start;
    logic        mcu_reset, wake_interrupt, mcu_idle, ram_low_power;
    logic        osc_pll_stop, baud_double;
    int          err_total, checks, cycles, resets, wakes, r0, w0, n;

    mcu_watchdog_idle_control #(.TICK_COUNT(TK), .WAKE_COUNT(WK)) DUT (
        .clock(clock), .rst_n(rst_n), .sfr_addr(sfr_addr),
        .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata), .xdata_addr(xdata_addr),
        .xdata_write(xdata_write), .xdata_read(xdata_read),
        .xdata_wdata(xdata_wdata), .xdata_rdata(xdata_rdata),
        .sof_detected(sof_detected), .usb_reset(usb_reset),
        .usb_reset_enable(usb_reset_enable),
        .external_interrupt_one_n(pin_n), .mcu_reset(mcu_reset),
        .wake_interrupt(wake_interrupt), .mcu_idle(mcu_idle),
        .ram_low_power(ram_low_power), .osc_pll_stop(osc_pll_stop),
        .baud_double(baud_double));

    wake_pin_model pin (.clock(clock), .start(pin_start), .hold(pin_hold), .pin_n(pin_n));

    initial
    begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Checking and bus helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks=%0d mismatches=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string msg);
        chk8({7'h00, got}, {7'h00, exp}, msg);
    endtask

    task automatic chkn(input int got, input int lo, input int hi, input string msg);
        checks++;
        if (got < lo || got > hi)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s got %0d want %0d..%0d", $time, msg, got, lo, hi);
        end
    endtask

    task automatic acc(input logic xd, input logic wr, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(negedge clock);
        xdata_addr  = a;
        xdata_wdata = d;
        sfr_addr    = a[7:0];
        sfr_wdata   = d;
        xdata_write = xd & wr;
        xdata_read  = xd & !wr;
        sfr_write   = !xd & wr;
        sfr_read    = !xd & !wr;
        @(negedge clock);
        q           = xd ? xdata_rdata : sfr_rdata;
        xdata_write = 1'h0;
        xdata_read  = 1'h0;
        sfr_write   = 1'h0;
        sfr_read    = 1'h0;
    endtask

    task automatic wrr(input logic xd, input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(xd, 1'h1, a, d, q);
    endtask

    task automatic rdc(input logic xd, input logic [15:0] a, input logic [7:0] e,
                       input string msg);
        logic [7:0] q;
        acc(xd, 1'h0, a, 8'h00, q);
        chk8(q, e, msg);
    endtask

    // Bounded wait for the next watchdog reset pulse
    task automatic wait_reset(input int maxc, output int cnt);
        int base;
        base = resets;
        cnt  = 0;
        while (resets == base && cnt < maxc)
        begin
            @(negedge clock);
            cnt++;
        end
    endtask

    task automatic pulse_pin(input logic [15:0] h);
        @(negedge clock);
        pin_hold  <= h;
        pin_start <= 1'h1;
        @(negedge clock);
        pin_start <= 1'h0;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (mcu_reset === 1'h1)
            resets++;
        if (wake_interrupt === 1'h1)
            wakes++;
        if (cycles == LIMIT)
        begin
            err_total++;
            $display("MISMATCH t=%0t run did not finish", $time);
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial
    begin
        {rst_n, sfr_write, sfr_read, xdata_write, xdata_read} = 5'h00;
        {sfr_addr, sfr_wdata, xdata_wdata, xdata_addr} = 40'h00_0000_0000;
        {sof_detected, usb_reset, usb_reset_enable, pin_start} = 4'h0;
        pin_hold = 16'h0000;
        {err_total, checks, cycles, resets, wakes} = {5{32'h0}};
        repeat (3) @(posedge clock);
        @(negedge clock) rst_n = 1'h1;
        rdc(1'h0, PCA, 8'h00, "power reset value");
        rdc(1'h1, WDA, 8'h00, "watchdog reset value");
        $display("test reset values done");

        wrr(1'h0, PCA, 8'hFE);
        rdc(1'h0, PCA, 8'h8C, "power flags");
        chk1(baud_double, 1'h1, "baud double on");
        rdc(1'h0, 16'h0086, 8'h00, "unmapped sfr");
        wrr(1'h1, 16'hFF92, 8'hFF);
        rdc(1'h1, WDA, 8'h00, "unmapped write ignored");
        wrr(1'h0, PCA, 8'h00);
        rdc(1'h0, PCA, 8'h00, "power cleared");
        $display("test registers done");

        wrr(1'h1, WDA, 8'h80);
        rdc(1'h1, WDA, 8'h80, "enable set");
        r0 = resets;
        repeat (40 * TK) @(negedge clock);
        chkn(resets - r0, 0, 0, "no count before frame");
        wrr(1'h1, WDA, 8'h00);
        rdc(1'h1, WDA, 8'h80, "enable kept on zero");
        @(negedge clock) sof_detected = 1'h1;
        @(negedge clock) sof_detected = 1'h0;
        r0 = resets;
        repeat (4)
        begin
            repeat (20 * TK) @(negedge clock);
            wrr(1'h1, WDA, 8'h01);
        end
        chkn(resets - r0, 0, 0, "serviced, no reset");
        wrr(1'h1, WDA, 8'hBF);
        rdc(1'h1, WDA, 8'h80, "service reads zero");
        repeat (16 * TK) @(negedge clock);
        wrr(1'h1, WDA, 8'h00);
        wait_reset(40 * TK, n);
        chkn(n, 14 * TK, 17 * TK, "zero write no restart");
        wrr(1'h1, WDA, 8'h01);
        wait_reset(40 * TK, n);
        chkn(n, 31 * TK, 32 * TK + 3, "expiry time");
        rdc(1'h1, WDA, 8'hC0, "cause set, enable kept");
        wrr(1'h1, WDA, 8'h80);
        rdc(1'h1, WDA, 8'hC0, "cause kept on zero");
        wrr(1'h1, WDA, 8'hC0);
        rdc(1'h1, WDA, 8'h80, "cause cleared");
        $display("test watchdog done");

        wrr(1'h1, WDA, 8'h01);
        repeat (20 * TK) @(negedge clock);
        wrr(1'h0, PCA, 8'h01);
        chk1(mcu_idle & ram_low_power & osc_pll_stop, 1'h1, "idle outputs");
        r0 = resets;
        w0 = wakes;
        repeat (40 * TK) @(negedge clock);
        chkn(resets - r0, 0, 0, "frozen in idle");
        wrr(1'h0, PCA, 8'h00);
        chk1(mcu_idle, 1'h1, "idle kept on zero");
        pulse_pin(16'(WK - 2));
        repeat (WK + 6) @(negedge clock);
        chk1(mcu_idle, 1'h1, "short pulse ignored");
        pulse_pin(16'(WK + 2));
        repeat (WK + 6) @(negedge clock);
        chk1(mcu_idle | ram_low_power | osc_pll_stop, 1'h0, "woken");
        chkn(wakes - w0, 1, 1, "one wake pulse");
        rdc(1'h0, PCA, 8'h00, "idle bit cleared");
        wait_reset(40 * TK, n);
        chkn(n, 8 * TK, 14 * TK, "resume from held count");
        $display("test idle done");

        @(negedge clock) usb_reset = 1'h1;
        @(negedge clock) usb_reset = 1'h0;
        rdc(1'h1, WDA, 8'hC0, "usb reset gated");
        @(negedge clock) {usb_reset, usb_reset_enable} = 2'h3;
        @(negedge clock) {usb_reset, usb_reset_enable} = 2'h0;
        rdc(1'h1, WDA, 8'h00, "usb reset clears");
        wrr(1'h1, WDA, 8'h80);
        r0 = resets;
        repeat (40 * TK) @(negedge clock);
        chkn(resets - r0, 0, 0, "frame needed again");
        $display("test usb reset done");
        close_out();
    end
endmodule
